// ### dcs_bank.sv
// Calibration memory, self-calibration and sync quadrant control register bank
// What this block does
// - Writing force update triggers one alignment update
// - Alarm bit set when alignment update needed
// - Bits 5:4 report calibration memory source
// - Divider code sets clock /4096 down to /32
// - Each code step halves settling time
// - Bit 7 flags self-calibration finished
// - Bit 6 starts self-calibration into static memory
// - Bit 5 flags factory transfer finished
// - Bit 4 copies factory memory into static
// - Bit 3 writes data register to memory
// - Bit 2 reads static memory into data
// - Bit 1 reads factory memory into data
// - Bit 0 forces defaults, stays set
// - Address register 0x10, 8 bits, resets zero
// - Data register 0x11, six bits, bidirectional
// - Register 0x15 reports current quadrant
// - External mode bit disables automatic quadrant
// - Bits 4:3 give external quadrant value
// - Soft reset self-clears, keeps memory, reports uncalibrated
// - Transfer paced by divided calibration clock
// - Manual mode suspends automatic alignment updates
`default_nettype none
`include "dcs_params.svh"
module dcs_bank
#(
   parameter int MEM_WORDS = `DCS_MEM_WORDS
)
(
   input  wire logic       clk_sys,
   input  wire logic       rst_n,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   output var  logic [7:0] reg_rdata,
   input  wire logic       soft_reset,
   input  wire logic       align_needed,
   input  wire logic [1:0] auto_quadrant,
   input  wire logic [5:0] factory_word,
   output var  logic [7:0] factory_addr,
   input  wire logic [5:0] start_a_word,
   output var  logic       alignment_update,
   output var  logic [1:0] current_quadrant,
   output var  logic       start_a_busy
);
   import dcs_pkg::*;

   // Walker and address register are 8 bits wide
   if (MEM_WORDS < 1 || MEM_WORDS > 256)
   begin
      $error("dcs_bank: MEM_WORDS must be 1 to 256");
   end

   // ************************************************************
   // State
   // ************************************************************
   typedef struct packed
   {
      logic [MEM_WORDS-1:0][5:0] static_cal_memory;
      dcs_state_t                state;
      dcs_source_t               calibration_source_status;
      logic [2:0]                calibration_clock_divider;
      logic                      start_a_done;
      logic                      transfer_done;
      logic                      static_mem_write_enable;
      logic                      static_mem_read_enable;
      logic                      factory_mem_read_enable;
      logic                      force_default_values;
      logic [7:0]                cal_mem_address;
      logic [5:0]                cal_mem_data;
      logic [7:0]                walk;
      logic [2:0]                settle;
      logic                      alignment_manual_mode;
      logic                      alignment_alarm;
      logic                      external_quadrant_mode;
      logic [1:0]                external_quadrant_value;
      logic [1:0]                current_quadrant;
      logic                      alignment_update;
      logic [7:0]                rdata;
      logic                      sr_meta;
      logic                      sr_sync;
      logic                      sr_prev;
      logic                      an_meta;
      logic                      an_sync;
      logic [7:0]                factory_index;
      logic                      start_a_running;
   } dcs_state_reg_t;

   dcs_state_reg_t st;
   dcs_state_reg_t next_st;
   logic           cal_tick;
   logic           wr_ctrl;
   logic           last_word;
   logic [7:0]     rd_mux;

   // ************************************************************
   // Calibration clock
   // ************************************************************
   dcs_cal_tick u_tick
   (
      .clk_sys  (clk_sys),
      .rst_n    (rst_n),
      .div_code (st.calibration_clock_divider),
      .tick     (cal_tick)
   );

   assign wr_ctrl   = reg_wr && (reg_addr == `DCS_ADDR_CAL_CTRL);
   assign last_word = (st.walk == 8'(MEM_WORDS - 1));

   // Read data mux over the documented map
   always_comb
   begin
      rd_mux = 8'h00;
      unique case (reg_addr)
         `DCS_ADDR_SYNC_CTRL:
            rd_mux = {5'h00, st.alignment_manual_mode, 1'b0, st.alignment_alarm};
         `DCS_ADDR_CAL_STATUS:
            rd_mux = {2'h0, st.calibration_source_status, 1'b0,
                      st.calibration_clock_divider};
         `DCS_ADDR_CAL_CTRL:
            rd_mux = {st.start_a_done, st.state == DCS_START_A, st.transfer_done,
                      st.state == DCS_XFER, st.static_mem_write_enable,
                      st.static_mem_read_enable, st.factory_mem_read_enable,
                      st.force_default_values};
         `DCS_ADDR_MEM_ADDR:
            rd_mux = st.cal_mem_address;
         `DCS_ADDR_MEM_DATA:
            rd_mux = {2'h0, st.cal_mem_data};
         `DCS_ADDR_QUAD_READ:
            rd_mux = {6'h00, st.current_quadrant};
         `DCS_ADDR_QUAD_SELECT:
            rd_mux = {2'h0, st.external_quadrant_mode, st.external_quadrant_value, 3'h0};
         default:
            rd_mux = 8'h00;
      endcase
   end

   // ************************************************************
   // Next state
   // ************************************************************
   always_comb
   begin
      next_st = st;
      next_st.alignment_update = 1'b0;
      next_st.sr_meta = soft_reset;
      next_st.sr_sync = st.sr_meta;
      next_st.sr_prev = st.sr_sync;
      next_st.an_meta = align_needed;
      next_st.an_sync = st.an_meta;
      if (reg_rd)
         next_st.rdata = rd_mux;

      // Register writes
      if (reg_wr)
      begin
         unique case (reg_addr)
            `DCS_ADDR_SYNC_CTRL:
            begin
               next_st.alignment_manual_mode = reg_wdata[`DCS_BIT_MANUAL_MODE];
               if (reg_wdata[`DCS_BIT_FORCE_UPDATE])
                  next_st.alignment_update = 1'b1;
            end
            `DCS_ADDR_CAL_STATUS:
               next_st.calibration_clock_divider = reg_wdata[2:0];
            `DCS_ADDR_MEM_ADDR:
               next_st.cal_mem_address = reg_wdata;
            `DCS_ADDR_MEM_DATA:
               next_st.cal_mem_data = reg_wdata[5:0];
            `DCS_ADDR_QUAD_SELECT:
            begin
               next_st.external_quadrant_mode  = reg_wdata[`DCS_BIT_EXT_MODE];
               next_st.external_quadrant_value = reg_wdata[`DCS_LSB_EXT_QUAD +: 2];
            end
            default:
            begin
            end
         endcase
      end

      // Control writes; mode bits ignored while a cycle runs
      if (wr_ctrl && st.state == DCS_IDLE)
      begin
         next_st.static_mem_write_enable = reg_wdata[`DCS_BIT_STATIC_CAL_MEMORY_WR];
         next_st.static_mem_read_enable  = reg_wdata[`DCS_BIT_STATIC_CAL_MEMORY_RD];
         next_st.factory_mem_read_enable = reg_wdata[`DCS_BIT_FACTORY_CAL_MEMORY_RD];
         next_st.force_default_values    = reg_wdata[`DCS_BIT_FORCE_DEFAULT];
         // Starts only honoured with bits 3:0 clear, as software must write them
         if (reg_wdata[3:0] == 4'h0)
         begin
            if (reg_wdata[`DCS_BIT_START_A_START])
            begin
               next_st.state        = DCS_START_A;
               next_st.start_a_done = 1'b0;
               next_st.walk         = 8'h00;
               next_st.settle       = 3'h0;
            end
            else if (reg_wdata[`DCS_BIT_XFER_START])
            begin
               next_st.state         = DCS_XFER;
               next_st.transfer_done = 1'b0;
               next_st.walk          = 8'h00;
            end
         end
         else if (reg_wdata[`DCS_BIT_FORCE_DEFAULT])
         begin
            next_st.state = DCS_DEFAULT;
            next_st.walk  = 8'h00;
         end
      end

      // Cycle engine: transfer writes one word per calibration tick, self-calibration one word per four ticks
      unique case (st.state)
         DCS_IDLE:
         begin
         end
         DCS_XFER:
         begin
            if (cal_tick)
            begin
               next_st.static_cal_memory[st.walk] = factory_word;
               next_st.walk = st.walk + 8'h01;
               if (last_word)
               begin
                  next_st.state = DCS_IDLE;
                  next_st.transfer_done = 1'b1;
                  next_st.calibration_source_status = DCS_SRC_FACTORY;
               end
            end
         end
         DCS_START_A:
         begin
            if (cal_tick)
            begin
               // Several settling ticks per word; slower clock gives longer settling
               next_st.settle = st.settle + 3'h1;
               if (st.settle == 3'(`DCS_START_A_SETTLE - 1))
               begin
                  next_st.settle = 3'h0;
                  next_st.static_cal_memory[st.walk] = start_a_word;
                  next_st.walk = st.walk + 8'h01;
                  if (last_word)
                  begin
                     next_st.state = DCS_IDLE;
                     next_st.start_a_done = 1'b1;
                     next_st.calibration_source_status = DCS_SRC_START_A;
                  end
               end
            end
         end
         DCS_DEFAULT:
         begin
            // Loading all words at once is cheap in flops and keeps the window short
            for (int i = 0; i < MEM_WORDS; i++)
               next_st.static_cal_memory[i] = `DCS_DEFAULT_WORD;
            next_st.state = DCS_IDLE;
            next_st.calibration_source_status = DCS_SRC_FORCE_DEFAULT_VALUES;
         end
      endcase

      // Hold defaults for as long as the bit stays set
      if (st.force_default_values && st.state == DCS_IDLE)
      begin
         for (int i = 0; i < MEM_WORDS; i++)
            next_st.static_cal_memory[i] = `DCS_DEFAULT_WORD;
         next_st.calibration_source_status = DCS_SRC_FORCE_DEFAULT_VALUES;
      end

      // Indirect access while enables are held
      if (st.state == DCS_IDLE && !st.force_default_values)
      begin
         if (st.static_mem_write_enable)
         begin
            if (32'(st.cal_mem_address) < MEM_WORDS)
               next_st.static_cal_memory[st.cal_mem_address] = st.cal_mem_data;
            next_st.calibration_source_status = DCS_SRC_USER;
         end
         else if (st.static_mem_read_enable)
         begin
            if (32'(st.cal_mem_address) < MEM_WORDS)
               next_st.cal_mem_data = st.static_cal_memory[st.cal_mem_address];
         end
         else if (st.factory_mem_read_enable)
         begin
            next_st.cal_mem_data = factory_word;
         end
      end

      // Alarm follows the sync logic, updates only auto unless manual
      next_st.alignment_alarm = st.an_sync;
      if (st.an_sync && !st.alignment_manual_mode)
         next_st.alignment_update = 1'b1;
      next_st.current_quadrant = st.external_quadrant_mode ?
                                 st.external_quadrant_value : auto_quadrant;

      // Soft reset edge: registers to defaults, memory untouched
      if (st.sr_sync && !st.sr_prev)
      begin
         next_st.state                     = DCS_IDLE;
         next_st.calibration_source_status = DCS_SRC_FORCE_DEFAULT_VALUES;
         next_st.calibration_clock_divider = 3'h0;
         next_st.start_a_done              = 1'b0;
         next_st.transfer_done             = 1'b0;
         next_st.static_mem_write_enable   = 1'b0;
         next_st.static_mem_read_enable    = 1'b0;
         next_st.factory_mem_read_enable   = 1'b0;
         next_st.force_default_values      = 1'b0;
         next_st.cal_mem_address           = 8'h00;
         next_st.cal_mem_data              = 6'h00;
         next_st.alignment_manual_mode     = 1'b0;
         next_st.external_quadrant_mode    = 1'b0;
         next_st.external_quadrant_value   = 2'h0;
      end

      // Outputs are taken from flops loaded with their own next values
      next_st.factory_index   = (next_st.state == DCS_XFER) ? next_st.walk
                                                            : next_st.cal_mem_address;
      next_st.start_a_running = (next_st.state == DCS_START_A);
   end

   // ************************************************************
   // Registers
   // ************************************************************
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         st <= '0;
         for (int i = 0; i < MEM_WORDS; i++)
            st.static_cal_memory[i] <= `DCS_DEFAULT_WORD;
      end
      else
      begin
         st <= next_st;
      end
   end

   // Factory memory is addressed by the walker during transfer, else by software
   assign factory_addr     = st.factory_index;
   assign reg_rdata        = st.rdata;
   assign alignment_update = st.alignment_update;
   assign current_quadrant = st.current_quadrant;
   assign start_a_busy     = st.start_a_running;
endmodule
`default_nettype wire

// ### dcs_params.svh
// Register offsets, field positions, reset values and timing counts for the calibration/sync bank
`ifndef DCS_PARAMS_SVH
`define DCS_PARAMS_SVH

`define DCS_ADDR_SYNC_CTRL    8'h02
`define DCS_ADDR_CAL_STATUS   8'h0e
`define DCS_ADDR_CAL_CTRL     8'h0f
`define DCS_ADDR_MEM_ADDR     8'h10
`define DCS_ADDR_MEM_DATA     8'h11
`define DCS_ADDR_QUAD_READ    8'h15
`define DCS_ADDR_QUAD_SELECT  8'h16

`define DCS_BIT_MANUAL_MODE   2
`define DCS_BIT_FORCE_UPDATE  1
`define DCS_BIT_ALARM         0
`define DCS_BIT_START_A_DONE  7
`define DCS_BIT_START_A_START 6
`define DCS_BIT_XFER_DONE     5
`define DCS_BIT_XFER_START    4
`define DCS_BIT_STATIC_CAL_MEMORY_WR       3
`define DCS_BIT_STATIC_CAL_MEMORY_RD       2
`define DCS_BIT_FACTORY_CAL_MEMORY_RD       1
`define DCS_BIT_FORCE_DEFAULT 0
`define DCS_BIT_EXT_MODE      5
`define DCS_LSB_EXT_QUAD      3
`define DCS_LSB_SOURCE        4

`define DCS_DEFAULT_WORD      6'h3f
`define DCS_DIV_BASE_LOG2     12
`define DCS_MEM_WORDS         256
`define DCS_START_A_SETTLE    4

`endif

// ### dcs_pkg.sv
// Types shared by the calibration and sync control bank
`default_nettype none
package dcs_pkg;
   typedef enum logic [1:0]
   {
      DCS_SRC_FORCE_DEFAULT_VALUES   = 2'h0,
      DCS_SRC_START_A = 2'h1,
      DCS_SRC_FACTORY = 2'h2,
      DCS_SRC_USER    = 2'h3
   } dcs_source_t;

   // Gray coded along idle -> transfer/start_a -> idle
   typedef enum logic [1:0]
   {
      DCS_IDLE    = 2'b00,
      DCS_XFER    = 2'b01,
      DCS_START_A = 2'b10,
      DCS_DEFAULT = 2'b11
   } dcs_state_t;
endpackage
`default_nettype wire

// ### dcs_cal_tick.sv
// Calibration clock divider: one tick every 4096 >> code converter cycles
`default_nettype none
`include "dcs_params.svh"
module dcs_cal_tick
#(
   parameter int BASE_LOG2 = `DCS_DIV_BASE_LOG2
)
(
   input  wire logic       clk_sys,
   input  wire logic       rst_n,
   input  wire logic [2:0] div_code,
   output var  logic       tick
);
   import dcs_pkg::*;

   // The 20-bit counter cannot serve a base beyond 2**20
   if (BASE_LOG2 < 8 || BASE_LOG2 > 20)
   begin
      $error("dcs_cal_tick: BASE_LOG2 out of range");
   end

   typedef struct packed
   {
      logic [19:0] count;
      logic        tick;
   } dcs_tick_state_t;

   dcs_tick_state_t st;
   dcs_tick_state_t next_st;
   logic     [19:0] limit;

   // Each code step halves the divisor and so halves settling time
   always_comb
   begin
      limit = (20'h1 << (BASE_LOG2[4:0] - {2'h0, div_code})) - 20'h1;
      next_st = st;
      next_st.tick = 1'b0;
      if (st.count >= limit)
      begin
         next_st.count = 20'h0;
         next_st.tick  = 1'b1;
      end
      else
      begin
         next_st.count = st.count + 20'h1;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
         st <= '0;
      else
         st <= next_st;
   end

   assign tick = st.tick;
endmodule
`default_nettype wire

// ### dcs_bank_asserts.sv
// Port-level assertions for the calibration and sync control bank
`default_nettype none
module dcs_bank_asserts
#(
   parameter int MEM_WORDS = 256
)
(
   input wire logic       clk_sys,
   input wire logic       rst_n,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic       soft_reset,
   input wire logic       align_needed,
   input wire logic       alignment_update,
   input wire logic [1:0] current_quadrant,
   input wire logic       start_a_busy
);
   timeunit 1ns;
   timeprecision 1ps;
   // ****
   // Shadow of the mode bits
   // ****
   logic       manual_q;
   logic       ext_q;
   logic [1:0] ext_val;
   logic [3:0] quiet;

   // Quiet counts cycles since any write, so a mode change settles before it is judged
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n || soft_reset)
      begin
         manual_q <= 1'b0;
         ext_q    <= 1'b0;
         ext_val  <= 2'h0;
         quiet    <= 4'h0;
      end
      else if (reg_wr)
      begin
         quiet <= 4'h0;
         if (reg_addr == 8'h02)
            manual_q <= reg_wdata[2];
         if (reg_addr == 8'h16)
         begin
            ext_q   <= reg_wdata[5];
            ext_val <= reg_wdata[4:3];
         end
      end
      else if (quiet != 4'hf)
         quiet <= quiet + 4'h1;
   end

   // ****
   // Properties
   // ****
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);

   property p_force_update;
      reg_wr && reg_addr == 8'h02 && reg_wdata[1] |-> ##[1:3] alignment_update;
   endproperty
   a_force_update: assert property (p_force_update)
      else $error("forced update gave no pulse");

   property p_alarm;
      align_needed [*5] ##0 (reg_rd && reg_addr == 8'h02) |=> reg_rdata[0];
   endproperty
   a_alarm: assert property (p_alarm)
      else $error("alarm bit low while update needed");

   property p_addr_back;
      reg_wr && reg_addr == 8'h10 ##1 !reg_wr ##1 (reg_rd && reg_addr == 8'h10)
         |=> reg_rdata == $past(reg_wdata, 3);
   endproperty
   a_addr_back: assert property (p_addr_back)
      else $error("address register readback differs");

   property p_quad_read;
      reg_rd && reg_addr == 8'h15 |=> reg_rdata == {6'h00, $past(current_quadrant)};
   endproperty
   a_quad_read: assert property (p_quad_read)
      else $error("quadrant readback differs from quadrant in use");

   property p_start_cause;
      $rose(start_a_busy)
         |-> $past(reg_wr) && $past(reg_addr) == 8'h0f && $past(reg_wdata[6])
             && $past(reg_wdata[3:0]) == 4'h0;
   endproperty
   a_start_cause: assert property (p_start_cause)
      else $error("self calibration began without a valid start write");

   property p_start_refused;
      reg_wr && reg_addr == 8'h0f && reg_wdata[3:0] != 4'h0 && !start_a_busy |=> !start_a_busy;
   endproperty
   a_start_refused: assert property (p_start_refused)
      else $error("start with low bits set was accepted");

   property p_soft_status;
      soft_reset [*8] ##0 (reg_rd && reg_addr == 8'h0e) |=> reg_rdata[5:4] == 2'b00;
   endproperty
   a_soft_status: assert property (p_soft_status)
      else $error("status not uncalibrated after soft reset");

   property p_manual_quiet;
      manual_q && quiet == 4'hf |-> !alignment_update;
   endproperty
   a_manual_quiet: assert property (p_manual_quiet)
      else $error("automatic update in manual mode");

   property p_ext_quad;
      ext_q && quiet == 4'hf |-> current_quadrant == ext_val;
   endproperty
   a_ext_quad: assert property (p_ext_quad)
      else $error("external quadrant not in use");

   c_start_a: cover property ($rose(start_a_busy));
   c_update: cover property (alignment_update);
   c_ext: cover property (ext_q && quiet == 4'hf);
endmodule

bind dcs_bank dcs_bank_asserts #(.MEM_WORDS(MEM_WORDS)) u_asserts
(
   .clk_sys(clk_sys), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
   .soft_reset(soft_reset), .align_needed(align_needed),
   .alignment_update(alignment_update), .current_quadrant(current_quadrant),
   .start_a_busy(start_a_busy)
);
`default_nettype wire

// ### dcs_bank_tb.sv
// Self-checking bench for the calibration and sync control bank
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   // ****
   // Signals and design
   // ****
   localparam int WORDS = 8;
   localparam logic [7:0] RST_ADDRS [7] = '{8'h0e, 8'h0f, 8'h10, 8'h11, 8'h15, 8'h16, 8'h33};
   logic       clk_sys;
   logic       rst_n;
   logic       reg_wr;
   logic       reg_rd;
   logic       soft_reset;
   logic       align_needed;
   logic [7:0] reg_addr;
   logic [7:0] reg_wdata;
   logic [7:0] reg_rdata;
   logic [1:0] auto_quadrant;
   logic [5:0] factory_word;
   logic [7:0] factory_addr;
   logic [5:0] start_a_word;
   logic       alignment_update;
   logic [1:0] current_quadrant;
   logic       start_a_busy;
   int         num_errors;
   int         checks_done;
   int         cyc;
   int         n;

   // Factory memory stand-in; its pattern never equals the default word at addresses 0 to 7
   assign factory_word = factory_addr[5:0] ^ 6'h2a;

   dcs_bank #(.MEM_WORDS(WORDS)) dut
   (
      .clk_sys(clk_sys), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .soft_reset(soft_reset), .align_needed(align_needed),
      .auto_quadrant(auto_quadrant), .factory_word(factory_word),
      .factory_addr(factory_addr), .start_a_word(start_a_word),
      .alignment_update(alignment_update), .current_quadrant(current_quadrant),
      .start_a_busy(start_a_busy)
   );

   // ****
   // Access and check tasks
   // ****
   task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic print_verdict();
      if (num_errors == 0 && checks_done > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // Requests rise at a falling edge and drop one cycle later
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_sys);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge clk_sys);
      reg_wr = 1'b0;
   endtask

   task automatic rc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
      @(negedge clk_sys);
      reg_rd = 1'b1;
      reg_addr = a;
      @(negedge clk_sys);
      reg_rd = 1'b0;
      chk("register read", reg_rdata & m, e);
   endtask

   task automatic memrd(input logic [7:0] sel, input logic [7:0] a, input logic [7:0] e);
      wr(8'h10, a);
      wr(8'h0f, sel);
      rc(8'h11, 8'hff, e);
      wr(8'h0f, 8'h00);
   endtask

   // Polls a done flag; the limit keeps a stuck cycle from hanging the run
   task automatic poll(input logic [7:0] m);
      cyc = 0;
      do
      begin
         @(negedge clk_sys);
         reg_rd = 1'b1;
         reg_addr = 8'h0f;
         @(negedge clk_sys);
         reg_rd = 1'b0;
         cyc += 2;
      end
      while ((reg_rdata & m) == 8'h00 && cyc < 4000);
   endtask

   task automatic span(input int lo, input int hi);
      chk("cycle count", 8'(cyc >= lo && cyc <= hi), 8'h01);
   endtask

   task automatic pulses(input int cnt);
      n = 0;
      repeat (cnt)
      begin
         if (alignment_update === 1'b1)
            n++;
         @(negedge clk_sys);
      end
   endtask

   // ****
   // Clock, watchdog and sequence
   // ****
   initial
   begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end

   // The sequence needs about 2500 cycles; this leaves ample margin
   initial
   begin
      repeat (20000) @(posedge clk_sys);
      num_errors++;
      print_verdict();
   end

   initial
   begin
      rst_n = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      soft_reset = 1'b0;
      align_needed = 1'b0;
      auto_quadrant = 2'h0;
      start_a_word = 6'h15;
      num_errors = 0;
      checks_done = 0;
      repeat (16) @(negedge clk_sys);
      rst_n = 1'b1;
      foreach (RST_ADDRS[i])
         rc(RST_ADDRS[i], 8'hff, 8'h00);
      memrd(8'h04, 8'h03, 8'h3f);
      for (int a = 5; a < 7; a++)
         memrd(8'h02, 8'(a), {2'b00, 6'(a) ^ 6'h2a});
      // Transfer at the two fastest dividers; duration must double
      wr(8'h0e, 8'h07);
      rc(8'h0e, 8'hff, 8'h07);
      wr(8'h0f, 8'h10);
      rc(8'h0f, 8'h30, 8'h10);
      poll(8'h20);
      span((WORDS - 1) * 32 - 8, (WORDS + 1) * 32);
      rc(8'h0e, 8'hff, 8'h27);
      memrd(8'h04, 8'h05, 8'h2f);
      wr(8'h0e, 8'h06);
      wr(8'h0f, 8'h10);
      rc(8'h0f, 8'h30, 8'h10);
      poll(8'h20);
      span((WORDS - 1) * 64 - 8, (WORDS + 1) * 64);
      // Starts with low bits set are refused
      wr(8'h0f, 8'h41);
      chk("busy", {7'h00, start_a_busy}, 8'h00);
      wr(8'h0f, 8'h11);
      rc(8'h0f, 8'h50, 8'h00);
      wr(8'h0f, 8'h00);
      wr(8'h0e, 8'h07);
      wr(8'h0f, 8'h40);
      chk("busy", {7'h00, start_a_busy}, 8'h01);
      poll(8'h80);
      span((4 * WORDS - 1) * 32 - 8, (4 * WORDS + 1) * 32);
      chk("busy", {7'h00, start_a_busy}, 8'h00);
      rc(8'h0e, 8'hff, 8'h17);
      memrd(8'h04, 8'h02, 8'h15);
      // User entry through the indirect registers
      wr(8'h10, 8'h04);
      rc(8'h10, 8'hff, 8'h04);
      wr(8'h11, 8'h0a);
      rc(8'h11, 8'hff, 8'h0a);
      wr(8'h0f, 8'h08);
      wr(8'h0f, 8'h00);
      rc(8'h0e, 8'h30, 8'h30);
      memrd(8'h04, 8'h04, 8'h0a);
      wr(8'h0f, 8'h01);
      repeat (400) @(negedge clk_sys);
      rc(8'h0f, 8'h01, 8'h01);
      rc(8'h0e, 8'h30, 8'h00);
      memrd(8'h04, 8'h04, 8'h3f);
      // Soft reset must keep the stored words
      wr(8'h10, 8'h01);
      wr(8'h11, 8'h11);
      wr(8'h0f, 8'h08);
      wr(8'h0f, 8'h00);
      soft_reset = 1'b1;
      repeat (10) @(negedge clk_sys);
      rc(8'h0e, 8'hff, 8'h00);
      soft_reset = 1'b0;
      rc(8'h10, 8'hff, 8'h00);
      memrd(8'h04, 8'h01, 8'h11);
      // Alignment updates: automatic, suspended, then forced once
      align_needed = 1'b1;
      pulses(10);
      chk("auto update", 8'(n > 0), 8'h01);
      rc(8'h02, 8'h01, 8'h01);
      wr(8'h02, 8'h04);
      rc(8'h02, 8'h04, 8'h04);
      pulses(4);
      pulses(20);
      chk("manual quiet", 8'(n), 8'h00);
      wr(8'h02, 8'h06);
      pulses(8);
      chk("forced update", 8'(n), 8'h01);
      align_needed = 1'b0;
      repeat (8) @(negedge clk_sys);
      rc(8'h02, 8'h01, 8'h00);
      auto_quadrant = 2'h2;
      repeat (4) @(negedge clk_sys);
      rc(8'h15, 8'hff, 8'h02);
      wr(8'h16, 8'h28);
      auto_quadrant = 2'h3;
      repeat (20) @(negedge clk_sys);
      rc(8'h15, 8'hff, 8'h01);
      chk("quadrant pin", {6'h00, current_quadrant}, 8'h01);
      rc(8'h16, 8'hff, 8'h28);
      wr(8'h16, 8'h00);
      repeat (4) @(negedge clk_sys);
      rc(8'h15, 8'hff, 8'h03);
      print_verdict();
   end
endmodule
`default_nettype wire
